//--- core/phy_misc_map.vh
`ifndef PHY_MISC_MAP_VH
`define PHY_MISC_MAP_VH
// register offsets
`define CFG_THREE_ADDR      6'h1e
`define SOFT_RST_ADDR       6'h1f
`define TEST_CH_ADDR        6'h25
`define XOVR_TMR_ADDR       6'h2c
`define IRQ_STAT_ADDR       6'h30
`define IRQ_EN_ADDR         6'h32
`define IRQ_CLR_ADDR        6'h33
// config three field positions
`define CFG_THREE_EXT_FD    11
`define CFG_THREE_ROBUST    9
`define CFG_THREE_FAST      8
`define CFG_THREE_INT_OE    7
`define CFG_THREE_FORCE_INT 6
`define CFG_THREE_FAIL      2
`define CFG_THREE_DONE      1
`define CFG_THREE_START     0
// writable bits of config three
`define CFG_THREE_WR_MASK   16'h0bc0
// soft reset field positions
`define SOFT_FULL_RST       15
`define SOFT_RESTART        14
// test channel field
`define TEST_CH_ALL         7
`define TEST_CH_SEL_HI      6
`define TEST_CH_SEL_LO      5
// reset values
`define CFG_THREE_RST       16'h0000
`define TEST_CH_UPPER       8'h04
`define TEST_CH_FIELD_RST   3'h0
`define XOVR_TMR_RST        16'h141f
`define IRQ_BANK_RST        3'h0
// timing
`define XOVR_STEP_MS        32
`define CLK_KHZ             250000
`define CABLE_MEAS_CYCLES   1000
`endif

//--- core/phy_misc_control_regs.v
`timescale 1ns/10ps
`include "phy_misc_map.vh"
// control and status bank seen by the management host
// one clock, synchronous reset, read data one cycle after the strobe
// the analog datapaths steered by these controls live elsewhere
module phy_misc_control_regs #(
	// cycles in one 32 ms crossover timer step
	parameter STEP_CYCLES = `XOVR_STEP_MS * `CLK_KHZ,
	// cycles taken by one reflectometry measurement
	parameter MEAS_CYCLES = `CABLE_MEAS_CYCLES
) (
	// clock and reset
	input  wire        i_clk,
	input  wire        i_sys_rst,
	// register port
	input  wire [5:0]  i_addr,
	input  wire [15:0] i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [15:0] o_rdata,
	// link status from analog side
	input  wire        i_partner_forced_100,
	input  wire        i_partner_full_duplex,
	input  wire        i_cable_meas_fail,
	input  wire        i_phy_event,
	// pad
	input  wire        i_pad_in,
	output wire        o_pad_out,
	output wire        o_pad_oe,
	output wire        o_powerdown,
	// controls to datapath
	output wire        o_full_duplex,
	output wire        o_robust_crossover,
	output wire        o_fast_crossover,
	output wire        o_fast_link_up_pd,
	output wire [3:0]  o_test_ch_en,
	output wire        o_xovr_timeout,
	output wire        o_meas_active,
	output wire        o_logic_rst,
	// interrupt
	output wire        o_irq
);

	// configuration three: only the writable bits are ever stored
	reg  [15:0] cfg_three_q;   // duplex, crossover, pad, force
	// reflectometry state
	reg         done_q;        // measurement complete
	reg         fail_q;        // measurement failed
	reg  [31:0] meas_cnt_q;    // cycles into the measurement
	// test mode and crossover timer settings
	reg  [2:0]  test_ch_q;     // test channel field, bits 7:5
	reg  [15:0] tmr_q;         // crossover timer, upper bits kept
	// crossover timer progress
	reg  [31:0] xovr_cnt_q;    // cycles within one step
	reg  [3:0]  xovr_step_q;   // 32 ms steps elapsed
	// one-cycle soft reset requests
	reg         restart_q;     // logic restart pulse
	reg         full_rst_q;    // full reset pulse
	// interrupt bank
	reg  [2:0]  stat_q;        // sticky events
	reg  [2:0]  en_q;          // event enables
	// decoded write strobes
	wire        wr_cfg_three;  // write to config three
	wire        wr_soft_rst;   // write to soft reset control
	wire        wr_irq_clr;    // write to interrupt clear
	wire        launch;        // start measurement
	wire        meas_end;      // measurement finishes
	// reset sources
	wire        rst_all;       // hardware or soft full reset
	wire        rst_logic;     // logic reset without registers
	// timer and interrupt helpers
	wire        xovr_step;     // end of one 32 ms step
	wire        xovr_last;     // programmed step count reached
	wire        xovr_run;      // timer allowed to advance
	wire [2:0]  ev;            // event vector
	wire        irq_pending;   // enabled event still set
	wire        force_irq;     // software forced interrupt

	// write decode shared by the processes below
	// addresses are word indexes; anything unmapped matches nothing
	assign wr_cfg_three = i_wr && (i_addr == `CFG_THREE_ADDR);
	assign wr_soft_rst  = i_wr && (i_addr == `SOFT_RST_ADDR);
	assign wr_irq_clr   = i_wr && (i_addr == `IRQ_CLR_ADDR);

	// full reset clears all but the read data and the pulse flops, restart spares the registers
	// both last exactly one cycle after the requesting write
	assign rst_all   = i_sys_rst | full_rst_q;
	assign rst_logic = rst_all | restart_q;

	// the start bit is a strobe: it launches and is never stored
	assign launch = wr_cfg_three &&
		i_wdata[`CFG_THREE_START];
	// last counted cycle of a running measurement
	assign meas_end = !done_q &&
		(meas_cnt_q == MEAS_CYCLES - 1);

	// soft reset bits self-clear after one cycle
	// only the hardware reset clears these two flops, so a full
	// reset pulse cannot cut itself short
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			// nothing pending after power-up
			full_rst_q <= 1'b0;
			restart_q  <= 1'b0;
		end else begin
			// a written one becomes a single-cycle pulse
			full_rst_q <= wr_soft_rst &&
				i_wdata[`SOFT_FULL_RST];
			restart_q  <= wr_soft_rst &&
				i_wdata[`SOFT_RESTART];
		end
	end

	// writable registers, kept across a restart
	// a full reset returns them to their defaults
	always @(posedge i_clk) begin
		if (rst_all) begin
			// defaults
			cfg_three_q <= `CFG_THREE_RST;
			test_ch_q   <= `TEST_CH_FIELD_RST;
			tmr_q       <= `XOVR_TMR_RST;
			en_q        <= `IRQ_BANK_RST;
		end else if (i_wr) begin
			case (i_addr)
			`CFG_THREE_ADDR: begin
				// start bit not stored, reserved bits dropped
				cfg_three_q <= i_wdata &
					`CFG_THREE_WR_MASK;
			end
			`TEST_CH_ADDR: begin
				// only the channel field is stored
				test_ch_q <= i_wdata[`TEST_CH_ALL:`TEST_CH_SEL_LO];
			end
			`XOVR_TMR_ADDR: begin
				// upper bits stored as written
				tmr_q <= i_wdata;
			end
			`IRQ_EN_ADDR: begin
				// one enable per event
				en_q <= i_wdata[2:0];
			end
			default: begin
				// other writes ignored
			end
			endcase
		end
	end

	// reflectometry measurement sequencer
	// a new launch while busy restarts the count from zero
	// the failure input is sampled only on the last cycle
	always @(posedge i_clk) begin
		if (rst_logic) begin
			// idle and complete after any reset
			done_q     <= 1'b1;
			fail_q     <= 1'b0;
			meas_cnt_q <= 32'h0000_0000;
		end else if (launch) begin
			// busy, old result discarded
			done_q     <= 1'b0;
			fail_q     <= 1'b0;
			meas_cnt_q <= 32'h0000_0000;
		end else if (meas_end) begin
			// result captured
			done_q <= 1'b1;
			fail_q <= i_cable_meas_fail;
		end else if (!done_q) begin
			// still measuring
			meas_cnt_q <= meas_cnt_q + 32'h0000_0001;
		end
	end

	// robust crossover resolution timer, 32 ms per step
	// runs only while robust crossover is on; the setting is
	// meaningless otherwise, so the count is held at zero
	// the step count saturates at the programmed value so that a
	// smaller value written mid-run still ends the wait
	assign xovr_run  = cfg_three_q[`CFG_THREE_ROBUST];
	assign xovr_step = (xovr_cnt_q == STEP_CYCLES - 1);
	assign xovr_last = (xovr_step_q >= tmr_q[3:0]);
	always @(posedge i_clk) begin
		if (rst_logic || !xovr_run) begin
			// held idle
			xovr_cnt_q  <= 32'h0000_0000;
			xovr_step_q <= 4'h0;
		end else if (xovr_step) begin
			// one more 32 ms step done
			xovr_cnt_q <= 32'h0000_0000;
			if (!xovr_last) begin
				xovr_step_q <= xovr_step_q + 4'h1;
			end
		end else begin
			// counting within a step
			xovr_cnt_q <= xovr_cnt_q + 32'h0000_0001;
		end
	end
	// (n+1)*32 ms elapsed, then one pulse per further step
	assign o_xovr_timeout = xovr_run && xovr_last &&
		xovr_step;

	// sticky events: done, fail, phy event
	// an event in the cycle of a clear wins over the clear, so
	// nothing that happens during the clear write is lost
	assign ev = {i_phy_event, meas_end & i_cable_meas_fail, meas_end};
	always @(posedge i_clk) begin
		if (rst_logic) begin
			// restart also drops old events
			stat_q <= `IRQ_BANK_RST;
		end else if (wr_irq_clr) begin
			// write one to clear, set wins
			stat_q <= (stat_q & ~i_wdata[2:0]) | ev;
		end else begin
			// collect
			stat_q <= stat_q | ev;
		end
	end

	// read mux, data one cycle after strobe, zero otherwise
	// reserved and write-only locations read as zero
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			// quiet bus after reset
			o_rdata <= 16'h0000;
		end else if (i_rd) begin
			case (i_addr)
			`CFG_THREE_ADDR: begin
				// stored bits plus measurement status
				o_rdata <= cfg_three_q |
					{13'h0000, fail_q, done_q, 1'b0};
			end
			`SOFT_RST_ADDR: begin
				// self-clearing bits read zero
				o_rdata <= 16'h0000;
			end
			`TEST_CH_ADDR: begin
				// fixed upper byte, field, zero low bits
				o_rdata <= {`TEST_CH_UPPER, test_ch_q, 5'h00};
			end
			`XOVR_TMR_ADDR: begin
				// whole word as stored
				o_rdata <= tmr_q;
			end
			`IRQ_STAT_ADDR: begin
				// sticky events
				o_rdata <= {13'h0000, stat_q};
			end
			`IRQ_EN_ADDR: begin
				// enables
				o_rdata <= {13'h0000, en_q};
			end
			default: begin
				// unmapped or write-only
				o_rdata <= 16'h0000;
			end
			endcase
		end else begin
			// data stands for one cycle only
			o_rdata <= 16'h0000;
		end
	end

	// duplex override against a forced 100 partner
	// with the bit clear the normal resolution passes through
	assign o_full_duplex =
		(cfg_three_q[`CFG_THREE_EXT_FD] && i_partner_forced_100) ?
		1'b1 : i_partner_full_duplex;

	// crossover mode controls straight from the register
	// fast crossover also forces the fast parallel-detect link-up
	assign o_robust_crossover =
		cfg_three_q[`CFG_THREE_ROBUST];
	assign o_fast_crossover   =
		cfg_three_q[`CFG_THREE_FAST];
	assign o_fast_link_up_pd  =
		cfg_three_q[`CFG_THREE_FAST];

	// test mode channel enables: all four, or one of a to d
	assign o_test_ch_en = test_ch_q[2] ? 4'hf :
		(4'h1 << test_ch_q[1:0]);

	// interrupt: any enabled sticky event, or forced by software
	assign irq_pending = |(stat_q & en_q);
	assign force_irq   = cfg_three_q[`CFG_THREE_FORCE_INT];
	assign o_irq       = irq_pending || force_irq;

	// shared pad: active-low interrupt out or powerdown in
	// the powerdown input is ignored while the pad drives
	assign o_pad_oe    = cfg_three_q[`CFG_THREE_INT_OE];
	assign o_pad_out   = ~o_irq;
	assign o_powerdown = !cfg_three_q[`CFG_THREE_INT_OE] &&
		!i_pad_in;

	// status for the datapath
	assign o_meas_active = !done_q;
	assign o_logic_rst   = rst_logic;

endmodule // phy_misc_control_regs

//--- testbench/host_model.sv
`timescale 1ns/10ps
// management host: drives the register port
module host_model (
	// clock and read data
	input  wire        i_clk,
	input  wire [15:0] i_rdata,
	// register port
	output reg  [5:0]  o_addr  = 6'h0,
	output reg  [15:0] o_wdata = 16'h0,
	output reg         o_wr    = 1'b0,
	output reg         o_rd    = 1'b0
);
	// one-cycle write strobe
	task wr(input [5:0] a, input [15:0] dv);
		begin
			@(posedge i_clk);
			o_addr  <= a;
			o_wdata <= dv;
			o_wr    <= 1'b1;
			@(posedge i_clk);
			o_wr    <= 1'b0;
		end
	endtask
	// one-cycle read strobe, data taken mid next cycle
	task rd(input [5:0] a, output [15:0] dv);
		begin
			@(posedge i_clk);
			o_addr <= a;
			o_rd   <= 1'b1;
			@(posedge i_clk);
			o_rd   <= 1'b0;
			#1 dv = i_rdata;
		end
	endtask
endmodule // host_model

//--- testbench/phy_misc_props.sv
`timescale 1ns/10ps
// port checker for the control register block
module phy_misc_props (
	input wire        i_clk, i_sys_rst, i_wr, i_rd,
	input wire [5:0]  i_addr,
	input wire [15:0] i_wdata, o_rdata,
	input wire        i_partner_forced_100, i_partner_full_duplex,
	input wire        i_pad_in, o_pad_out, o_pad_oe, o_powerdown,
	input wire        o_full_duplex, o_fast_crossover, o_fast_link_up_pd,
	input wire        o_meas_active, o_logic_rst, o_irq,
	input wire [3:0]  o_test_ch_en
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	property p_pad; o_pad_out == !o_irq; endproperty
	a_pad: assert property (p_pad) else $error("pad drive");
	property p_pd; o_powerdown == (!o_pad_oe && !i_pad_in); endproperty
	a_pd: assert property (p_pd) else $error("powerdown");
	property p_fd;
		!i_partner_forced_100 |-> o_full_duplex == i_partner_full_duplex;
	endproperty
	a_fd: assert property (p_fd) else $error("duplex");
	property p_fast; o_fast_link_up_pd == o_fast_crossover; endproperty
	a_fast: assert property (p_fast) else $error("fast link");
	property p_tm; $onehot(o_test_ch_en) || o_test_ch_en == 4'hf; endproperty
	a_tm: assert property (p_tm) else $error("test chan");
	property p_rsv;
		i_rd && i_addr == 6'h1e |=> o_rdata[5:3] == 3'h0 && !o_rdata[10];
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved");
	property p_done;
		i_rd && i_addr == 6'h1e |=> o_rdata[1] == !$past(o_meas_active);
	endproperty
	a_done: assert property (p_done) else $error("done bit");
	property p_meas;
		$rose(o_meas_active) |-> $past(i_wr && i_addr == 6'h1e && i_wdata[0]);
	endproperty
	a_meas: assert property (p_meas) else $error("launch");
	property p_lrst;
		i_wr && i_addr == 6'h1f && (|i_wdata[15:14]) |=> ##[0:1] o_logic_rst;
	endproperty
	a_lrst: assert property (p_lrst) else $error("restart");
	c_meas: cover property ($rose(o_meas_active));
	c_irq: cover property ($rose(o_irq));
	c_rst: cover property ($rose(o_logic_rst));
endmodule // phy_misc_props
bind phy_misc_control_regs phy_misc_props u_props (.*);

//--- testbench/phy_misc_control_regs_tb.sv
`timescale 1ns/10ps
module phy_misc_control_regs_tb;
	reg i_clk = 0, i_sys_rst = 1, i_partner_forced_100 = 1, pd_n = 1;
	reg i_partner_full_duplex = 0, i_cable_meas_fail = 1, i_phy_event = 0;
	wire [5:0] i_addr;
	wire [15:0] i_wdata, o_rdata;
	wire [3:0] o_test_ch_en;
	wire i_wr, i_rd, o_pad_out, o_pad_oe, o_powerdown, o_full_duplex;
	wire o_robust_crossover, o_fast_crossover, o_fast_link_up_pd, o_irq;
	wire o_xovr_timeout, o_meas_active, o_logic_rst;
	wire i_pad_in = o_pad_oe ? o_pad_out : pd_n; // shared pad level
	integer n_errors = 0, tests_run = 0, k;
	reg [15:0] v;
	always #2 i_clk = ~i_clk;
	phy_misc_control_regs #(.STEP_CYCLES(8), .MEAS_CYCLES(5)) dut (.*);
	host_model h (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr),
		.o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
	task chk(input [15:0] g, input [15:0] e);
		begin
			tests_run = tests_run + 1;
			if (g !== e) begin
				n_errors = n_errors + 1;
				$display("FAIL %0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task rc(input [5:0] a, input [15:0] e);
		begin h.rd(a, v); chk(v, e); end
	endtask
	task tally_and_finish;
		begin
			$display("errors %0d checks %0d", n_errors, tests_run);
			if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
			else $display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task t_defaults;
		begin
			rc(6'h1e, 16'h0002);
			rc(6'h1f, 16'h0000);
			rc(6'h25, 16'h0400);
			rc(6'h2c, 16'h141f);
			rc(6'h3f, 16'h0000);
		end
	endtask
	task t_cfg;
		begin
			h.wr(6'h1e, 16'h0ff8);
			rc(6'h1e, 16'h0bc2);
			chk({o_irq, o_pad_oe, o_fast_link_up_pd, o_full_duplex}, 4'hf);
			@(posedge i_clk);
			pd_n <= 1'b0;
			h.wr(6'h1e, 16'h0000);
			rc(6'h1e, 16'h0002);
			chk({o_irq, o_pad_oe, o_full_duplex, o_powerdown}, 4'h1);
		end
	endtask
	task t_meas;
		begin
			h.wr(6'h1e, 16'h0001);
			rc(6'h1e, 16'h0000);
			for (k = 0; k < 50 && o_meas_active; k = k + 1) @(posedge i_clk);
			if (o_meas_active) begin n_errors = n_errors + 1; tally_and_finish; end
			rc(6'h1e, 16'h0006);
			@(posedge i_clk);
			i_phy_event <= 1'b1;
			@(posedge i_clk) i_phy_event <= 1'b0;
			rc(6'h30, 16'h0007);
			chk(o_irq, 1'b0);
			h.wr(6'h32, 16'h0004);
			rc(6'h32, 16'h0004);
			chk(o_irq, 1'b1);
			h.wr(6'h33, 16'h0007);
			rc(6'h30, 16'h0000);
			chk(o_irq, 1'b0);
		end
	endtask
	task t_tm;
		for (k = 0; k < 5; k = k + 1) begin
			h.wr(6'h25, 16'h0400 | (k << 5));
			@(posedge i_clk);
			chk(o_test_ch_en, k == 4 ? 4'hf : 4'h1 << k);
		end
	endtask
	task t_tmr;
		begin
			h.wr(6'h2c, 16'h1411);
			h.wr(6'h1e, 16'h0200);
			for (k = 0; k < 100 && !o_xovr_timeout; k = k + 1) @(negedge i_clk);
			chk(k >= 13 && k <= 18, 1'b1);
			chk({o_robust_crossover, o_fast_crossover}, 2'h2);
		end
	endtask
	task t_rst;
		begin
			h.wr(6'h1e, 16'h0080);
			h.wr(6'h1f, 16'h4000);
			rc(6'h1e, 16'h0082);
			h.wr(6'h1f, 16'h8000);
			rc(6'h1e, 16'h0002);
			rc(6'h2c, 16'h141f);
			rc(6'h1f, 16'h0000);
		end
	endtask
	initial begin
		repeat (8) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		t_defaults;
		t_cfg;
		t_meas;
		t_tm;
		t_tmr;
		t_rst;
		tally_and_finish;
	end
endmodule // phy_misc_control_regs_tb
